/* File: logic/dmc_cache_ctrl.sv */
// Direct-mapped write-through cache controller with tag and data stores
//
// Overview of operation
// [R01] Low 13 address bits index both tag store and data store.
// [R02] Upper 11 address bits form the compared and written tag.
// [R03] Five tag bits are constant ones, acting as valid bits.
// [R04] Hit is active high, the AND of every tag slice comparison.
// [R05] Processor takes cache data on hit, waits for memory otherwise.
// [R06] At power-up every tag entry is cleared to zero.
// [R07] Read miss writes returned data and valid tag at the index.
// [R08] Read hit returns cached word without starting main memory.
// [R09] Same index, different upper bits is a miss; line is replaced.
// [R10] Every write goes to main memory; the cache is updated as in R11.
// [R11] Cacheable full-word writes always update; byte writes only on a hit.
// [R12] Unbuffered writes hold the processor until memory write ends.
// [R13] Optional buffered writes let the processor continue meanwhile.
// [R14] Decision strobe is the request delayed by the match time.
// [R15] Processor memory cycle is two 50 ns clocks; hits fit one.
// [R16] On memory service, the strobe path also writes the cache.
// [R17] Hit indication is latched by the strobe for the cache write.
// [R18] I/O addresses always force a miss and are never cached.
// [R19] DMA writes taken while idle update a cached line on an address match.
// [R20] Without snooping, DMA buffer regions are forced uncached.
// [R21] Hit held low and cache writes blocked during tag clear.
// [R22] Wait driven low from strobe to memory acknowledge on a miss.
`timescale 1ns/1ps
module dmc_cache_ctrl
#(
    parameter bit BUFFERED_WRITES = 1'b0,
    parameter bit SNOOP_EN = 1'b1,
    parameter logic [23:0] IO_BASE = 24'hff0000,
    parameter logic [23:0] IO_MASK = 24'hff0000,
    parameter logic [23:0] DMA_BASE = 24'hfe0000,
    parameter logic [23:0] DMA_MASK = 24'hff0000,
    parameter int MATCH_CYC = dmc_pkg::MATCH_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic cpu_valid,
    input wire dmc_pkg::dmc_req_s cpu_req,
    output logic cpu_wait_n,
    output logic cpu_done,
    output logic [dmc_pkg::DATA_W-1:0] cpu_rdata,
    output logic cache_hit,
    input wire logic dma_valid,
    input wire dmc_pkg::dmc_req_s dma_req,
    output logic mem_valid,
    output dmc_pkg::dmc_req_s mem_cmd,
    input wire logic mem_ack,
    input wire logic [dmc_pkg::DATA_W-1:0] mem_rdata,
    output logic tag_clear
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The tag store answers one cycle after its address is latched
    if (MATCH_CYC < 2 || MATCH_CYC > 255 ||
        dmc_pkg::TAG_W != dmc_pkg::SLICES * dmc_pkg::SLICE_W)
    begin : g_bad_cfg
        $error("MATCH_CYC or tag slicing not supported");
    end

    localparam logic [dmc_pkg::CNT_W-1:0] MATCH_LOAD =
        dmc_pkg::CNT_W'(MATCH_CYC - 1);
    localparam logic [dmc_pkg::IDX_W-1:0] IDX_LAST = '1;

    // ------------------------------------------------------------
    // Reset and state
    // ------------------------------------------------------------
    logic rst_sync_n;
    dmc_pkg::dmc_state_e state;
    dmc_pkg::dmc_req_s req;
    logic req_dma;
    logic [dmc_pkg::CNT_W-1:0] cnt;
    logic wr_ok_lat;
    logic clearing;
    logic [dmc_pkg::IDX_W-1:0] clr_idx;
    logic wb_pend;
    logic [dmc_pkg::TAG_W-1:0] tag_rd;
    logic [dmc_pkg::DATA_W-1:0] data_rd;

    dmc_rst_sync u_rst_sync
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    // ------------------------------------------------------------
    // Address split and tag compare
    // ------------------------------------------------------------
    wire [dmc_pkg::IDX_W-1:0] idx = req.addr[dmc_pkg::IDX_W-1:0];
    // [R02] Upper address bits
    wire [dmc_pkg::UTAG_W-1:0] utag =
        req.addr[dmc_pkg::ADDR_W-1:dmc_pkg::IDX_W];
    // [R03] Valid bits tied high
    wire [dmc_pkg::TAG_W-1:0] tag_ref = {dmc_pkg::VALID_ONES, utag};
    logic [dmc_pkg::SLICES-1:0] slice_eq;

    for (genvar s = 0; s < dmc_pkg::SLICES; s++)
    begin : g_slice
        assign slice_eq[s] =
            tag_rd[s*dmc_pkg::SLICE_W +: dmc_pkg::SLICE_W] ==
            tag_ref[s*dmc_pkg::SLICE_W +: dmc_pkg::SLICE_W];
    end

    // [R04] AND across slices
    wire raw_match = &slice_eq;
    // [R18] I/O region decode
    wire io_region = (req.addr & IO_MASK) == IO_BASE;
    // [R20] DMA region uncached
    wire dma_region = !SNOOP_EN && ((req.addr & DMA_MASK) == DMA_BASE);
    wire uncached = io_region || dma_region;
    // [R09] [R21] Mismatch or sweep misses
    wire match_now = raw_match && !uncached && !clearing;
    wire full_word = req.be == dmc_pkg::BE_FULL;
    // [R11] Full word or hit
    wire wr_ok_now = !uncached && !clearing && (full_word || match_now);

    // ------------------------------------------------------------
    // Decision strobe and actions
    // ------------------------------------------------------------
    // [R14] Request delayed by match time
    wire strobe = (state == dmc_pkg::ST_MATCH) && (cnt == '0);
    wire hold_go = (state == dmc_pkg::ST_HOLD) && !wb_pend;
    wire decide = strobe || hold_go;
    wire dec_dma = decide && req_dma;
    // [R08] Read hit served locally
    wire dec_rd_hit = decide && !req_dma && !req.we && match_now;
    wire need_port = decide && !req_dma && !dec_rd_hit;
    wire port_busy = need_port && wb_pend;
    wire dec_buf_wr = need_port && !wb_pend && req.we && BUFFERED_WRITES;
    wire dec_start = need_port && !wb_pend && !dec_buf_wr;
    wire fill_ack = (state == dmc_pkg::ST_FILL) && mem_ack;
    wire wb_ack = wb_pend && mem_ack;
    wire take_cpu = (state == dmc_pkg::ST_IDLE) && !clearing && cpu_valid;
    wire take_dma = (state == dmc_pkg::ST_IDLE) && !clearing && dma_valid
        && dma_req.we && SNOOP_EN;
    // [R22] Wait from strobe until memory answers
    wire wait_now = clearing || (need_port && !dec_buf_wr)
        || (state == dmc_pkg::ST_FILL && !mem_ack)
        || (state == dmc_pkg::ST_HOLD && wb_pend);

    // ------------------------------------------------------------
    // Cache write path
    // ------------------------------------------------------------
    logic [dmc_pkg::DATA_W-1:0] merged;

    // Byte merge keeps untouched lanes of an already valid line
    for (genvar b = 0; b < dmc_pkg::BE_W; b++)
    begin : g_merge
        assign merged[b*8 +: 8] = req.be[b] ? req.wdata[b*8 +: 8]
            : data_rd[b*8 +: 8];
    end

    // [R07] Fill on read miss
    wire fill_wr = fill_ack && !req.we && !uncached;
    // [R12] Update at memory ack
    wire wt_wr = fill_ack && req.we && wr_ok_lat;
    // [R13] Update when buffered
    wire buf_wr = dec_buf_wr && wr_ok_now;
    // [R19] Snoop update on match
    wire snoop_wr = dec_dma && match_now;
    // [R21] Sweep owns the stores
    wire upd_wr = !clearing && (fill_wr || wt_wr || buf_wr || snoop_wr);
    // [R16] Strobe path writes cache
    wire cwr_en = clearing || upd_wr;
    // [R01] Index drives both stores
    wire [dmc_pkg::IDX_W-1:0] cwr_idx = clearing ? clr_idx : idx;
    // [R06] Cleared entries are zero
    wire [dmc_pkg::TAG_W-1:0] cwr_tag = clearing ? dmc_pkg::TAG_EMPTY
        : tag_ref;
    wire [dmc_pkg::DATA_W-1:0] cwr_data = fill_wr ? mem_rdata : merged;

    dmc_ram #(.AW(dmc_pkg::IDX_W), .DW(dmc_pkg::TAG_W)) u_tag_ram
    (
        .ref_clk(ref_clk),
        .clk_en(clk_en),
        .wr_en(cwr_en),
        .wr_addr(cwr_idx),
        .wr_data(cwr_tag),
        .rd_addr(idx),
        .rd_data(tag_rd)
    );

    dmc_ram #(.AW(dmc_pkg::IDX_W), .DW(dmc_pkg::DATA_W)) u_data_ram
    (
        .ref_clk(ref_clk),
        .clk_en(clk_en),
        .wr_en(cwr_en && !clearing),
        .wr_addr(cwr_idx),
        .wr_data(cwr_data),
        .rd_addr(idx),
        .rd_data(data_rd)
    );

    // ------------------------------------------------------------
    // Next-state selection
    // ------------------------------------------------------------
    dmc_pkg::dmc_state_e next_state;
    wire done_now = dec_rd_hit || (dec_buf_wr && !req_dma) || fill_ack;

    always_comb
    begin
        next_state = state;
        if (take_cpu || take_dma)
        begin
            next_state = dmc_pkg::ST_MATCH;
        end
        else if (dec_dma || dec_rd_hit || dec_buf_wr || fill_ack)
        begin
            next_state = dmc_pkg::ST_IDLE;
        end
        else if (dec_start)
        begin
            next_state = dmc_pkg::ST_FILL;
        end
        else if (port_busy)
        begin
            next_state = dmc_pkg::ST_HOLD;
        end
    end

    // ------------------------------------------------------------
    // Power-up tag clear sweep
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            clearing <= 1'b1;
            clr_idx <= '0;
        end
        else if (clk_en && clearing)
        begin
            clr_idx <= clr_idx + 1'b1;
            clearing <= clr_idx != IDX_LAST;
        end
    end

    // ------------------------------------------------------------
    // Request capture and timing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state <= dmc_pkg::ST_IDLE;
            req <= '0;
            req_dma <= 1'b0;
            cnt <= '0;
            wr_ok_lat <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            if (take_dma || take_cpu)
            begin
                req <= take_dma ? dma_req : cpu_req;
                req_dma <= take_dma;
                cnt <= MATCH_LOAD;
            end
            else if (state == dmc_pkg::ST_MATCH)
            begin
                cnt <= cnt - 1'b1;
            end
            // [R17] Latch hit at strobe
            if (decide)
            begin
                wr_ok_lat <= wr_ok_now;
            end
        end
    end

    // ------------------------------------------------------------
    // Processor side outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            cpu_wait_n <= 1'b0;
            cpu_done <= 1'b0;
            cpu_rdata <= '0;
            cache_hit <= 1'b0;
        end
        else if (clk_en)
        begin
            cpu_done <= done_now && !req_dma;
            cpu_wait_n <= !wait_now;
            // [R05] Data source follows hit
            if (dec_rd_hit)
            begin
                cpu_rdata <= data_rd;
            end
            else if (fill_ack && !req.we)
            begin
                cpu_rdata <= mem_rdata;
            end
            if (decide && !req_dma)
            begin
                cache_hit <= match_now;
            end
        end
    end

    // ------------------------------------------------------------
    // Main memory port and write buffer
    // ------------------------------------------------------------
    // One memory port: a buffered write and a fill never overlap,
    // because a fill waits in the hold state until the buffer drains
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            mem_valid <= 1'b0;
            mem_cmd <= '0;
            wb_pend <= 1'b0;
        end
        else if (clk_en)
        begin
            // [R10] Every write reaches memory
            mem_valid <= dec_start || dec_buf_wr || (mem_valid && !mem_ack);
            if (dec_start || dec_buf_wr)
            begin
                mem_cmd.addr <= req.addr;
                mem_cmd.wdata <= req.wdata;
                mem_cmd.be <= req.we ? req.be : dmc_pkg::BE_FULL;
                mem_cmd.we <= req.we;
            end
            // [R13] Buffer holds write
            wb_pend <= dec_buf_wr || (wb_pend && !wb_ack);
        end
    end
    assign tag_clear = clearing;

endmodule

/* File: logic/dmc_pkg.sv */
// Shared widths, constants, carriers and states of the cache controller
package dmc_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BE_W = DATA_W / 8;
    localparam int IDX_W = 13;
    localparam int UTAG_W = ADDR_W - IDX_W;
    localparam int VALID_W = 5;
    localparam int TAG_W = UTAG_W + VALID_W;
    localparam int SLICE_W = 8;
    localparam int SLICES = TAG_W / SLICE_W;

    // ------------------------------------------------------------
    // Tag field values and full byte-enable mask
    // ------------------------------------------------------------
    localparam logic [VALID_W-1:0] VALID_ONES = 5'h1f;
    localparam logic [TAG_W-1:0] TAG_EMPTY = 16'h0000;
    localparam logic [BE_W-1:0] BE_FULL = 2'h3;

    // ------------------------------------------------------------
    // Timing: tag address-to-match time, rounded up to cycles
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int MATCH_TIME_PS = 37000;
    localparam int MATCH_CYC =
        (MATCH_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0] be;
        logic we;
    } dmc_req_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MATCH = 2'b01,
        ST_FILL = 2'b10,
        ST_HOLD = 2'b11
    } dmc_state_e;

endpackage

/* File: logic/dmc_ram.sv */
// Single-port-write, registered-read store used for tags and data
`timescale 1ns/1ps
module dmc_ram
#(
    parameter int AW = 13,
    parameter int DW = 16
)
(
    input wire logic ref_clk,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] cells [0:(1<<AW)-1];

    // No reset: tag contents are defined by the controller's clear sweep
    always_ff @(posedge ref_clk)
    begin
        if (clk_en)
        begin
            if (wr_en)
            begin
                cells[wr_addr] <= wr_data;
            end
            rd_data <= cells[rd_addr];
        end
    end

endmodule

/* File: logic/dmc_rst_sync.sv */
// Reset release synchroniser: asynchronous assert, two-stage release
`timescale 1ns/1ps
module dmc_rst_sync
(
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic rst_sync_n
);

    logic stage1;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            stage1 <= 1'b1;
            rst_sync_n <= stage1;
        end
    end

endmodule

/* File: verif/dmc_cache_ctrl_assertions.sv */
// Assertion checker for the cache controller top ports
`timescale 1ns/1ps
module dmc_cache_chk
#(
    parameter int MATCH_CYC = 4,
    parameter logic [23:0] IO_BASE = 24'hff0000,
    parameter logic [23:0] IO_MASK = 24'hff0000
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cpu_valid,
    input wire dmc_pkg::dmc_req_s cpu_req,
    input wire logic cpu_wait_n,
    input wire logic cpu_done,
    input wire logic [dmc_pkg::DATA_W-1:0] cpu_rdata,
    input wire logic cache_hit,
    input wire logic mem_valid,
    input wire dmc_pkg::dmc_req_s mem_cmd,
    input wire logic mem_ack,
    input wire logic [dmc_pkg::DATA_W-1:0] mem_rdata,
    input wire logic tag_clear
);
    // ----------------
    // Request tracking
    // ----------------
    localparam int DEC = MATCH_CYC + 1;
    logic busy;
    dmc_pkg::dmc_req_s req_q;
    wire logic take = cpu_valid && !busy && !tag_clear;
    wire logic io_q = (req_q.addr & IO_MASK) == IO_BASE;

    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            busy <= 1'b0;
        else if (take)
            busy <= 1'b1;
        else if (cpu_done)
            busy <= 1'b0;

    always_ff @(posedge ref_clk)
        if (take)
            req_q <= cpu_req;

    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_clear_quiet: assert property (
        tag_clear |-> !cache_hit && !cpu_done && !cpu_wait_n)
        else $error("activity during tag clear");
    chk_strobe_delay: assert property (
        take |=> (!cpu_done && !mem_valid)[*4] ##1
        ((cpu_done && cache_hit && !mem_valid) || (mem_valid && !cpu_done)))
        else $error("decision not at strobe");
    chk_read_hit: assert property (
        take && !cpu_req.we |-> ##DEC cache_hit == cpu_done)
        else $error("hit flag and completion disagree");
    chk_write_through: assert property (
        take && cpu_req.we |-> ##DEC mem_valid && mem_cmd.we
        && mem_cmd.addr == req_q.addr && mem_cmd.wdata == req_q.wdata)
        else $error("write not sent to memory");
    chk_fill_cmd: assert property (
        mem_valid && !mem_cmd.we |-> mem_cmd.be == 2'h3
        && mem_cmd.addr == req_q.addr)
        else $error("bad memory read command");
    chk_mem_hold: assert property (
        mem_valid && !mem_ack |=> mem_valid && $stable(mem_cmd))
        else $error("memory request not held");
    chk_ack_done: assert property (
        mem_valid && mem_ack |=> !mem_valid && cpu_done && cpu_wait_n)
        else $error("no completion after ack");
    chk_fill_data: assert property (
        mem_valid && mem_ack && !mem_cmd.we |=> cpu_rdata == $past(mem_rdata))
        else $error("read data not from memory");
    chk_miss_wait: assert property (
        mem_valid |-> !cpu_wait_n)
        else $error("processor not held");
    chk_io_miss: assert property (
        cpu_done && io_q |-> !cache_hit)
        else $error("uncached address hit");

    cover property (take && !cpu_req.we ##DEC cpu_done && cache_hit);
    cover property (mem_valid && mem_ack && mem_cmd.we);
    cover property (cpu_done && io_q);
endmodule

bind dmc_cache_ctrl dmc_cache_chk #(.MATCH_CYC(MATCH_CYC), .IO_BASE(IO_BASE),
    .IO_MASK(IO_MASK)) u_chk (.ref_clk, .rst_n, .cpu_valid, .cpu_req,
    .cpu_wait_n, .cpu_done, .cpu_rdata, .cache_hit, .mem_valid, .mem_cmd,
    .mem_ack, .mem_rdata, .tag_clear);

/* File: verif/dmc_mem_model.sv */
// Main memory model that answers the controller and takes DMA writes
`timescale 1ns/1ps
module dmc_mem_model
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] lat,
    input wire logic mem_valid,
    input wire dmc_pkg::dmc_req_s mem_cmd,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    input wire logic dma_valid,
    input wire dmc_pkg::dmc_req_s dma_req
);
    logic [15:0] mem [logic [23:0]];
    logic [2:0] cnt;

    function automatic logic [15:0] peek(input logic [23:0] x);
        return mem.exists(x) ? mem[x] : x[15:0] ^ {8'h5a, x[23:16]};
    endfunction

    // Disabled lanes keep the stored byte
    function automatic logic [15:0] merge(input dmc_pkg::dmc_req_s q);
        logic [15:0] o;
        o = peek(q.addr);
        if (q.be[0]) o[7:0] = q.wdata[7:0];
        if (q.be[1]) o[15:8] = q.wdata[15:8];
        return o;
    endfunction

    // ----------------
    // Answer after lat cycles; data toggles so stale values never match
    // ----------------
    always @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
        begin
            cnt <= 3'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0;
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (dma_valid && dma_req.we)
                mem[dma_req.addr] = merge(dma_req);
            if (mem_valid && !mem_ack && cnt >= lat)
            begin
                mem_ack <= 1'b1;
                cnt <= 3'h0;
                if (mem_cmd.we)
                    mem[mem_cmd.addr] = merge(mem_cmd);
                else
                    mem_rdata <= peek(mem_cmd.addr);
            end
            else if (mem_valid && !mem_ack)
                cnt <= cnt + 3'h1;
        end
endmodule

/* File: verif/tb_direct_mapped_write_through_cache_ctrl.sv */
// Self-checking bench: directed and random traffic against a memory model
`timescale 1ns/1ps
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin \
    errors++; $display("wrong value %0t %s", $time, m); end end
module tb_direct_mapped_write_through_cache_ctrl;
    localparam logic [23:0] IO_B = 24'hff0000;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cpu_valid = 1'b0;
    logic dma_valid = 1'b0;
    logic [2:0] lat = 3'h0;
    dmc_pkg::dmc_req_s cpu_req = '0;
    dmc_pkg::dmc_req_s dma_req = '0;
    dmc_pkg::dmc_req_s mem_cmd;
    logic cpu_wait_n, cpu_done, cache_hit, mem_valid, mem_ack, tag_clear;
    logic [15:0] cpu_rdata, mem_rdata;
    logic [31:0] seed = 32'h0e940e45;
    logic [31:0] r;
    logic [23:0] a;
    logic [15:0] rmem [logic [23:0]];
    logic [10:0] rtag [logic [12:0]];
    int errors = 0;
    int num_checks = 0;
    int n;

    dmc_cache_ctrl #(.IO_BASE(IO_B), .IO_MASK(IO_B)) dut (.ref_clk, .rst_n,
        .clk_en(1'b1), .cpu_valid, .cpu_req, .cpu_wait_n, .cpu_done,
        .cpu_rdata, .cache_hit, .dma_valid, .dma_req, .mem_valid, .mem_cmd,
        .mem_ack, .mem_rdata, .tag_clear);
    dmc_mem_model mem (.ref_clk, .rst_n, .lat, .mem_valid, .mem_cmd,
        .mem_ack, .mem_rdata, .dma_valid, .dma_req);

    always #5 ref_clk = ~ref_clk;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic is_io(input logic [23:0] x);
        return (x & IO_B) == IO_B;
    endfunction

    // ----------------
    // Bus tasks with the expected cache state worked out beforehand
    // ----------------
    task automatic op(input logic [23:0] x, input logic we,
        input logic [1:0] be, input logic [15:0] wd);
        logic h;
        logic [15:0] ev;
        int k;
        h = !is_io(x) && rtag.exists(x[12:0]) && rtag[x[12:0]] == x[23:13];
        ev = rmem.exists(x) ? rmem[x] : x[15:0] ^ {8'h5a, x[23:16]};
        if (we && be[0]) ev[7:0] = wd[7:0];
        if (we && be[1]) ev[15:8] = wd[15:8];
        if (we) rmem[x] = ev;
        if (!is_io(x) && (!we || be == 2'h3 || h)) rtag[x[12:0]] = x[23:13];
        cpu_req = '{x, wd, be, we};
        cpu_valid = 1'b1;
        @(posedge ref_clk);
        #1 cpu_valid = 1'b0;
        // hold off until the controller answers
        for (k = 0; k < 200 && cpu_done !== 1'b1; k++) @(posedge ref_clk) #1;
        `CHK(cpu_done, 1'b1, "no completion")
        `CHK(cache_hit, h, "hit flag")
        if (!we) `CHK(cpu_rdata, ev, "read data")
        `CHK(cpu_wait_n, 1'b1, "still waiting")
        @(posedge ref_clk); // next request only after completion
        #1;
    endtask

    task automatic dma(input logic [23:0] x, input logic [15:0] wd);
        dma_req = '{x, wd, 2'h3, 1'b1};
        dma_valid = 1'b1;
        rmem[x] = wd;
        @(posedge ref_clk);
        #1 dma_valid = 1'b0;
        // Snoop update lands MATCH_CYC cycles after the pulse
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    task results();
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #400000;
        errors++;
        results();
    end

    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        repeat (5) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        cpu_req = '{24'h000100, 16'h0, 2'h3, 1'b0};
        cpu_valid = 1'b1;
        @(posedge ref_clk);
        #1 cpu_valid = 1'b0;
        r = 0;
        for (n = 1; tag_clear !== 1'b0 && n < 9000; n++)
        begin
            @(posedge ref_clk) #1;
            if (cpu_done === 1'b1) r = 1;
        end
        `CHK(r[0], 1'b0, "answer during clear")
        `CHK(n >= 8192 && n <= 8200, 1'b1, "clear length")
        repeat (2) @(posedge ref_clk) #1;
        // fill on miss, then hit; other upper bits replace the line
        op(24'h012345, 1'b0, 2'h3, 16'h0);
        op(24'h012345, 1'b0, 2'h3, 16'h0);
        op(24'h412345, 1'b0, 2'h3, 16'h0);
        op(24'h412345, 1'b0, 2'h3, 16'h0);
        op(24'h012345, 1'b0, 2'h3, 16'h0);
        // full write fills, byte write only on a hit
        op(24'h020010, 1'b1, 2'h3, 16'hbeef);
        op(24'h020010, 1'b0, 2'h3, 16'h0);
        op(24'h030020, 1'b1, 2'h1, 16'h1234);
        op(24'h030020, 1'b0, 2'h3, 16'h0);
        op(24'h030020, 1'b1, 2'h2, 16'habcd);
        op(24'h030020, 1'b0, 2'h3, 16'h0);
        op(24'hff0040, 1'b0, 2'h3, 16'h0);
        op(24'hff0040, 1'b0, 2'h3, 16'h0);
        // DMA write to a cached word is seen by the next hit
        dma(24'h020010, 16'h5a5a);
        op(24'h020010, 1'b0, 2'h3, 16'h0);
        repeat (400)
        begin
            r = rnd();
            a = {6'h0, r[5:4], 11'h0, r[8:6], 2'h0};
            if (r[3:0] == 4'h0) a[23:16] = 8'hff;
            lat = r[11:9];
            if (r[15:13] == 3'h0 && !is_io(a)) dma(a, r[31:16]);
            else op(a, r[12], r[13] ? 2'h3 : {r[14], !r[14]}, r[31:16]);
        end
        results();
    end
endmodule
